// [hw/pio_port.sv]
// pio_port: pin logic and data/configuration registers of ports a, b, c and d.
// assumes the microcontroller bus, pins and supply comparator are asynchronous to
// clk_sys and are synchronised here; configuration and logic-array inputs are on clk_sys.
// Summary of operation
// - in input mode a pin-input read returns the live pin level.
// - a bus write to the output latch register stores the byte per pin.
// - a latch bit drives its pin only when direction is one and the logic array is not selected.
// - reading the output latch returns the latch, not the pin.
// - ports a and b may carry logic-array outputs instead of the latch.
// - address-in pins of a and b may be captured by the address strobe.
// - bits 3..0 of ports a and b offer a fast slew rate.
// - bits 7..4 of ports a and b offer open-drain, driving low only.
// - only port a offers data port mode, which removes its general i/o use.
// - ports a and b can output the latched bus address.
// - port c pins given to jtag are lost to every other function.
// - every port c pin offers open-drain drive.
// - port c bit 2 may be the standby supply input.
// - port c bit 4 may signal main supply below battery.
// - port c has no mode-control register.
// - port c bit 7 may be the data byte enable input.
// - port d has three pins and no mode-control register.
// - port d pins may carry logic-array outputs.
// - each port d pin offers a fast slew rate.
// - port d bit 0 may be the address strobe input, driven by the microcontroller.
// - port d bit 1 may be the common clock input.
// - port d bit 2 may be an active-low chip select disabling memories and registers.
// - each register bit acts on the same-index pin of its port.
// - direction one makes an output, zero an input, default input.
// - on ports a and b control zero is i/o, one is address out, default zero.
`timescale 1ns/10ps
`default_nettype none
module pio_port (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// static configuration and logic-array terms
	input wire pio_pkg::pio_cfg_t cfg,
	input wire pio_pkg::pio_general_logic_array_t general_logic_array,
	// microcontroller bus
	input wire logic mcu_sel,
	input wire logic mcu_wr_n,
	input wire logic mcu_rd_n,
	input wire logic mcu_ale,
	input wire logic [7:0] mcu_addr,
	input wire logic [7:0] mcu_wdata,
	output logic [7:0] mcu_rdata,
	output logic mcu_rdata_oe,
	// port a pins
	input wire logic [7:0] pa_in,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe,
	output logic [7:0] pa_fast_slew,
	// port b pins
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	output logic [7:0] pb_fast_slew,
	// port c pins
	input wire logic [7:0] pc_in,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe,
	// port d pins
	input wire logic [2:0] pd_in,
	output logic [2:0] pd_out,
	output logic [2:0] pd_oe,
	output logic [2:0] pd_fast_slew,
	// supply comparator, high while main supply is below battery
	input wire logic batt_low,
	// dedicated functions toward the rest of the chip
	output logic [7:0] addr_in_a,
	output logic [7:0] addr_in_b,
	output logic address_strobe,
	output logic common_clock_input,
	output logic data_byte_enable,
	output logic mem_disable
);
	import pio_pkg::*;

	logic [SYNC_W-1:0] s1_q, s2_q;
	logic [7:0] out_q [4];
	logic [7:0] dir_q [4];
	logic [7:0] drv_q [4];
	logic [7:0] ctl_q [2];
	logic [7:0] alat_q, ain_a_q, ain_b_q, rdata_q;
	logic wr_act_q, rd_oe_q;
	logic [7:0] pa_o_q, pa_oe_q, pb_o_q, pb_oe_q, pc_o_q, pc_oe_q;
	logic [2:0] pd_o_q, pd_oe_q;
	logic strobe_q, clk_q, dbe_q, mdis_q;

	// two-flop synchroniser for every input from outside the clock domain
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {pa_in, pb_in, pc_in, pd_in, mcu_sel, mcu_wr_n, mcu_rd_n, mcu_ale,
				mcu_addr, mcu_wdata, batt_low};
			s2_q <= s1_q;
		end
	end

	// synchronised fields
	wire [7:0] pa_s = s2_q[47:40];
	wire [7:0] pb_s = s2_q[39:32];
	wire [7:0] pc_s = s2_q[31:24];
	wire [2:0] pd_s = s2_q[23:21];
	wire sel_s = s2_q[20];
	wire wr_n_s = s2_q[19];
	wire rd_n_s = s2_q[18];
	wire ale_pin_s = s2_q[17];
	wire [7:0] addr_s = s2_q[16:9];
	wire [7:0] wbus_s = s2_q[8:1];
	wire batt_s = s2_q[0];

	// dedicated port d inputs and chip select gating
	wire ale_s = cfg.ale_on_d0 ? pd_s[D_ALE_BIT] : ale_pin_s;
	wire io_en = !(cfg.csi_on_d2 && pd_s[D_CSI_BIT]);
	wire [7:0] wdata = cfg.a_data_port ? pa_s : mcu_wdata_sel(wbus_s);
	wire wr_act = sel_s && !wr_n_s && io_en;
	wire rd_act = sel_s && !rd_n_s && io_en;
	wire wr_p = wr_act && !wr_act_q;

	// register decode: upper bits pick the group, low two bits the port
	wire [5:0] grp = addr_s[7:2];
	wire [1:0] prt = addr_s[1:0];
	wire ab_port = (prt == PORT_A) || (prt == PORT_B);
	wire [7:0] pmask = (prt == PORT_D) ? MASK_D : 8'hFF;
	wire wr_out = wr_p && (grp == OFS_OUT_LATCH);
	wire wr_dir = wr_p && (grp == OFS_DIR);
	wire wr_drv = wr_p && (grp == OFS_DRIVE);
	wire wr_ctl = wr_p && (grp == OFS_CTRL) && ab_port;

	// identity helper keeps the bus data path explicit
	function automatic logic [7:0] mcu_wdata_sel(input logic [7:0] d);
		mcu_wdata_sel = d;
	endfunction : mcu_wdata_sel

	// pin levels seen by reads, jtag pins read as zero
	wire [7:0] pin_rd [4];
	assign pin_rd[0] = pa_s;
	assign pin_rd[1] = pb_s;
	assign pin_rd[2] = pc_s & ~cfg.c_jtag;
	assign pin_rd[3] = {5'h00, pd_s};

	// read data mux; unmapped offsets and missing control registers read zero
	wire [7:0] rd_mux =
		(grp == OFS_PIN_IN) ? pin_rd[prt] :
		(grp == OFS_OUT_LATCH) ? out_q[prt] :
		(grp == OFS_DIR) ? dir_q[prt] :
		(grp == OFS_DRIVE) ? drv_q[prt] :
		(grp == OFS_CTRL && ab_port) ? ctl_q[prt[0]] : 8'h00;

	// configuration and data registers, all clear to zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				out_q[i] <= REG_RST;
				dir_q[i] <= REG_RST;
				drv_q[i] <= REG_RST;
			end
			ctl_q[0] <= REG_RST;
			ctl_q[1] <= REG_RST;
			wr_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			if (wr_out) out_q[prt] <= wdata & pmask;
			if (wr_dir) dir_q[prt] <= wdata & pmask;
			if (wr_drv) drv_q[prt] <= wdata & pmask;
			if (wr_ctl) ctl_q[prt[0]] <= wdata;
		end
	end

	// bus read answer held while the read strobe stands
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
			rd_oe_q <= 1'b0;
		end else begin
			rdata_q <= rd_act ? rd_mux : 8'h00;
			rd_oe_q <= rd_act;
		end
	end

	// address latch and optional capture of address-in pins by the strobe
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			alat_q <= 8'h00;
			ain_a_q <= 8'h00;
			ain_b_q <= 8'h00;
		end else begin
			if (ale_s) alat_q <= addr_s;
			if (ale_s || !cfg.latch_addr_in) begin
				ain_a_q <= pa_s;
				ain_b_q <= pb_s;
			end
		end
	end

	// value and enable of a port a/b pin before drive type is applied
	function automatic logic [15:0] ab_src(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] ctl, input logic [7:0] gsel, input logic [7:0] go,
		input logic [7:0] goe, input logic [7:0] adr);
		logic [7:0] v, e;
		v = 8'h00;
		e = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (gsel[i]) begin
				v[i] = go[i];
				e[i] = goe[i];
			end else if (ctl[i]) begin
				v[i] = adr[i];
				e[i] = dir[i];
			end else begin
				v[i] = latch[i];
				e[i] = dir[i];
			end
		end
		ab_src = {v, e};
	endfunction : ab_src

	// open-drain pins drive only a low level
	function automatic logic [15:0] od_apply(input logic [15:0] ve, input logic [7:0] od);
		od_apply = {ve[15:8] & ~od, ve[7:0] & ~(od & ve[15:8])};
	endfunction : od_apply

	// per-port drive computation
	wire [15:0] a_raw = ab_src(out_q[0], dir_q[0], ctl_q[0], cfg.gsel_a, general_logic_array.a_o,
		general_logic_array.a_oe, alat_q);
	wire [15:0] b_raw = ab_src(out_q[1], dir_q[1], ctl_q[1], cfg.gsel_b, general_logic_array.b_o,
		general_logic_array.b_oe, alat_q);
	wire [15:0] a_dr = od_apply(a_raw, drv_q[0] & OD_MASK_AB);
	wire [15:0] b_dr = od_apply(b_raw, drv_q[1] & OD_MASK_AB);
	wire [15:0] c_dr = od_apply({out_q[2], dir_q[2]}, drv_q[2] & OD_MASK_C);
	wire [7:0] c_func = cfg.c_jtag | {cfg.dbe_on_c7, 2'b00, cfg.batt_on_c4, 1'b0,
		cfg.stby_on_c2, 2'b00};
	wire [2:0] d_val = (cfg.gsel_d & general_logic_array.d_o) | (~cfg.gsel_d & out_q[3][2:0]);
	wire [2:0] d_en = (cfg.gsel_d & general_logic_array.d_oe) | (~cfg.gsel_d & dir_q[3][2:0]);
	wire [2:0] d_ded = {cfg.csi_on_d2, cfg.clk_on_d1, cfg.ale_on_d0};

	// registered pin drivers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pa_o_q <= 8'h00;
			pa_oe_q <= 8'h00;
			pb_o_q <= 8'h00;
			pb_oe_q <= 8'h00;
			pc_o_q <= 8'h00;
			pc_oe_q <= 8'h00;
			pd_o_q <= 3'h0;
			pd_oe_q <= 3'h0;
		end else begin
			pa_o_q <= cfg.a_data_port ? rdata_q : a_dr[15:8];
			pa_oe_q <= cfg.a_data_port ? {8{rd_act}} : a_dr[7:0];
			pb_o_q <= b_dr[15:8];
			pb_oe_q <= b_dr[7:0];
			pc_o_q <= c_dr[15:8];
			pc_oe_q <= c_dr[7:0] & ~c_func;
			if (cfg.batt_on_c4 && !cfg.c_jtag[C_BATT_BIT]) begin
				pc_o_q[C_BATT_BIT] <= batt_s;
				pc_oe_q[C_BATT_BIT] <= 1'b1;
			end
			pd_o_q <= d_val;
			pd_oe_q <= d_en & ~d_ded;
		end
	end

	// dedicated input functions passed to the rest of the chip
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			strobe_q <= 1'b0;
			clk_q <= 1'b0;
			dbe_q <= 1'b0;
			mdis_q <= 1'b0;
		end else begin
			strobe_q <= ale_s;
			clk_q <= cfg.clk_on_d1 & pd_s[D_CLK_BIT];
			dbe_q <= cfg.dbe_on_c7 & ~cfg.c_jtag[C_DBE_BIT] & pc_s[C_DBE_BIT];
			mdis_q <= ~io_en;
		end
	end

	// outputs straight from flops; slew selects are register bits
	assign mcu_rdata = rdata_q;
	assign mcu_rdata_oe = rd_oe_q;
	assign pa_out = pa_o_q;
	assign pa_oe = pa_oe_q;
	assign pa_fast_slew = drv_q[0] & SLEW_MASK_AB;
	assign pb_out = pb_o_q;
	assign pb_oe = pb_oe_q;
	assign pb_fast_slew = drv_q[1] & SLEW_MASK_AB;
	assign pc_out = pc_o_q;
	assign pc_oe = pc_oe_q;
	assign pd_out = pd_o_q;
	assign pd_oe = pd_oe_q;
	assign pd_fast_slew = drv_q[3][2:0] & SLEW_MASK_D[2:0];
	assign addr_in_a = ain_a_q;
	assign addr_in_b = ain_b_q;
	assign address_strobe = strobe_q;
	assign common_clock_input = clk_q;
	assign data_byte_enable = dbe_q;
	assign mem_disable = mdis_q;
endmodule : pio_port
`default_nettype wire

// [hw/pio_pkg.sv]
// pio_pkg: constants, register offsets and carrier types for the port block.
// assumes one 20 MHz system clock; all offsets are relative to the io register block base.
package pio_pkg;
	// clock and sizing
	localparam int CLK_HZ = 20_000_000;
	localparam int PW = 8; // pins per full port
	localparam int DW = 3; // pins on port d
	localparam int SYNC_W = 48; // async inputs gathered for synchronising
	// port indices
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;
	localparam logic [1:0] PORT_D = 2'h3;
	// register groups, low two address bits pick the port
	localparam logic [5:0] OFS_PIN_IN = 6'h00; // port_pin_input
	localparam logic [5:0] OFS_OUT_LATCH = 6'h01; // port_output_latch
	localparam logic [5:0] OFS_DIR = 6'h02;
	localparam logic [5:0] OFS_DRIVE = 6'h03;
	localparam logic [5:0] OFS_CTRL = 6'h04; // ports a and b only
	// reset values and masks
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] MASK_D = 8'h07;
	localparam logic [7:0] OD_MASK_AB = 8'hF0;
	localparam logic [7:0] SLEW_MASK_AB = 8'h0F;
	localparam logic [7:0] OD_MASK_C = 8'hFF;
	localparam logic [7:0] SLEW_MASK_D = 8'h07;
	// dedicated pin positions
	localparam int C_STBY_BIT = 2;
	localparam int C_BATT_BIT = 4;
	localparam int C_DBE_BIT = 7;
	localparam int D_ALE_BIT = 0;
	localparam int D_CLK_BIT = 1;
	localparam int D_CSI_BIT = 2;
	// static configuration set when the device is programmed
	typedef struct packed {
		logic a_data_port;
		logic ale_on_d0;
		logic clk_on_d1;
		logic csi_on_d2;
		logic dbe_on_c7;
		logic stby_on_c2;
		logic batt_on_c4;
		logic latch_addr_in;
		logic [7:0] c_jtag;
		logic [7:0] gsel_a;
		logic [7:0] gsel_b;
		logic [2:0] gsel_d;
	} pio_cfg_t;
	// combinatorial general_logic_array outputs and their enable terms
	typedef struct packed {
		logic [7:0] a_o;
		logic [7:0] a_oe;
		logic [7:0] b_o;
		logic [7:0] b_oe;
		logic [2:0] d_o;
		logic [2:0] d_oe;
	} pio_general_logic_array_t;
endpackage : pio_pkg

// [test/pio_port_chk.sv]
// pio_port_chk: port-level assertions on pio_port, bound to every instance.
// assumes cfg only changes while sys_rst is high.
`timescale 1ns/10ps
`default_nettype none
module pio_port_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// watched inputs
	input wire pio_pkg::pio_cfg_t cfg,
	input wire pio_pkg::pio_general_logic_array_t general_logic_array,
	input wire logic mcu_sel,
	input wire logic mcu_rd_n,
	input wire logic [2:0] pd_in,
	// watched outputs
	input wire logic [7:0] mcu_rdata,
	input wire logic mcu_rdata_oe,
	input wire logic [7:0] pa_oe,
	input wire logic [7:0] pa_fast_slew,
	input wire logic [7:0] pb_fast_slew,
	input wire logic [7:0] pc_oe,
	input wire logic [2:0] pd_out,
	input wire logic [2:0] pd_oe,
	input wire logic mem_disable
);
	import pio_pkg::*;
	// port d pins taken by dedicated inputs
	wire logic [2:0] d_ded = {cfg.csi_on_d2, cfg.clk_on_d1, cfg.ale_on_d0};
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// port a enables and read data are quiet at the first edge after reset
	property p_rst_clear; $fell(sys_rst) |-> pa_oe == 8'h00 && mcu_rdata == 8'h00; endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("not clear after reset");
	property p_slew; pa_fast_slew[7:4] == 4'h0 && pb_fast_slew[7:4] == 4'h0; endproperty
	a_slew: assert property (p_slew) else $error("slew on upper nibble");
	property p_jtag; (pc_oe & cfg.c_jtag) == 8'h00; endproperty
	a_jtag: assert property (p_jtag) else $error("jtag pin driven");
	property p_c_ded; !(cfg.stby_on_c2 && pc_oe[2]) && !(cfg.dbe_on_c7 && pc_oe[7]); endproperty
	a_c_ded: assert property (p_c_ded) else $error("dedicated c pin driven");
	property p_d_ded; (pd_oe & d_ded) == 3'h0; endproperty
	a_d_ded: assert property (p_d_ded) else $error("dedicated d pin driven");
	property p_csi; (cfg.csi_on_d2 && pd_in[D_CSI_BIT])[*4] |-> mem_disable; endproperty
	a_csi: assert property (p_csi) else $error("chip select ignored");
	property p_rd_answer; (mcu_sel && !mcu_rd_n && !cfg.csi_on_d2)[*4] |-> mcu_rdata_oe; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rd_end; mcu_rd_n[*4] |-> !mcu_rdata_oe && mcu_rdata == 8'h00; endproperty
	a_rd_end: assert property (p_rd_end) else $error("read data left standing");
	property p_general_logic_array_d; $stable(general_logic_array)[*3] |-> ((pd_out ^ general_logic_array.d_o) & pd_oe & cfg.gsel_d & ~d_ded)
		== 3'h0 && ((pd_oe ^ general_logic_array.d_oe) & cfg.gsel_d & ~d_ded) == 3'h0; endproperty
	a_general_logic_array_d: assert property (p_general_logic_array_d) else $error("logic array not on port d");
endmodule : pio_port_chk
bind pio_port pio_port_chk i_pio_port_chk (.clk_sys, .sys_rst, .cfg, .general_logic_array, .mcu_sel,
	.mcu_rd_n, .pd_in, .mcu_rdata, .mcu_rdata_oe, .pa_oe, .pa_fast_slew, .pb_fast_slew,
	.pc_oe, .pd_out, .pd_oe, .mem_disable);
`default_nettype wire

// [test/pio_mcu.sv]
// pio_mcu: microcontroller bus model that drives the register bus of pio_port.
// assumes clk_sys from the bench; strobes, address and driven data move 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pio_mcu (
	// clock
	input wire logic clk_sys,
	// bus toward the device
	output logic mcu_sel,
	output logic mcu_wr_n,
	output logic mcu_rd_n,
	output logic mcu_ale,
	output logic [7:0] mcu_addr,
	output logic [7:0] mcu_wdata,
	input wire logic [7:0] mcu_rdata
);
	int hold = 4; // strobe low time in cycles, raised for slow cycles
	initial begin
		{mcu_sel, mcu_wr_n, mcu_rd_n, mcu_ale} = 4'b0110;
		mcu_addr = 8'h00;
		mcu_wdata = 8'h00;
	end
	// released data lines keep changing so stale data is never seen
	always @(posedge clk_sys) if (mcu_wr_n) mcu_wdata <= ~mcu_wdata;
	// one bus cycle, read data taken at the last low edge, then 3 idle cycles
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		@(posedge clk_sys) #1;
		mcu_addr = a;
		mcu_wdata = d;
		{mcu_sel, mcu_wr_n, mcu_rd_n} = {1'b1, !w, w};
		repeat (hold) @(posedge clk_sys);
		r = mcu_rdata;
		#1;
		{mcu_sel, mcu_wr_n, mcu_rd_n} = 3'b011;
		repeat (3) @(posedge clk_sys) #1;
	endtask : access
	// address strobe pulse carrying an address
	task automatic strobe(input logic [7:0] a);
		@(posedge clk_sys) #1;
		mcu_addr = a;
		mcu_ale = 1'b1;
		repeat (4) @(posedge clk_sys) #1;
		mcu_ale = 1'b0;
		repeat (3) @(posedge clk_sys) #1;
	endtask : strobe
endmodule : pio_mcu
`default_nettype wire

// [test/test_pio_port.sv]
// test_pio_port: self-checking bench for the port block.
// assumes pio_mcu as bus partner and the bound checker; cfg changes under reset.
`timescale 1ns/10ps
`default_nettype none
module test_pio_port;
	import pio_pkg::*;
	// bench inputs
	logic clk_sys, sys_rst, batt_low;
	pio_cfg_t cfg, c;
	pio_general_logic_array_t general_logic_array;
	logic [7:0] pa_in, pb_in, pc_in, q;
	logic [2:0] pd_in;
	int fail_count, checks_done;
	// partner bus and device outputs
	wire logic mcu_sel, mcu_wr_n, mcu_rd_n, mcu_ale;
	wire logic [7:0] mcu_addr, mcu_wdata;
	logic [7:0] mcu_rdata, pa_out, pa_oe, pa_fast_slew, pb_out, pb_oe, pb_fast_slew;
	logic [7:0] pc_out, pc_oe, addr_in_a, addr_in_b;
	logic [2:0] pd_out, pd_oe, pd_fast_slew;
	logic mcu_rdata_oe, address_strobe, common_clock_input, data_byte_enable, mem_disable;
	pio_port i_pio_port (.clk_sys, .sys_rst, .cfg, .general_logic_array, .mcu_sel, .mcu_wr_n, .mcu_rd_n,
		.mcu_ale, .mcu_addr, .mcu_wdata, .mcu_rdata, .mcu_rdata_oe, .pa_in, .pa_out, .pa_oe,
		.pa_fast_slew, .pb_in, .pb_out, .pb_oe, .pb_fast_slew, .pc_in, .pc_out, .pc_oe,
		.pd_in, .pd_out, .pd_oe, .pd_fast_slew, .batt_low, .addr_in_a, .addr_in_b,
		.address_strobe, .common_clock_input, .data_byte_enable, .mem_disable);
	pio_mcu i_pio_mcu (.clk_sys, .mcu_sel, .mcu_wr_n, .mcu_rd_n, .mcu_ale, .mcu_addr,
		.mcu_wdata, .mcu_rdata);
	// 50 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_pio_mcu.access(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_pio_mcu.access(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rd
	// reset for 12 cycles with a new static configuration
	task automatic rst(input pio_cfg_t n);
		sys_rst = 1'b1;
		cfg = n;
		repeat (12) @(posedge clk_sys) #1;
		sys_rst = 1'b0;
	endtask : rst
	// watchdog, the run needs about 21 us
	initial begin
		#200us;
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		test_done();
	end
	// test sequence
	initial begin
		{general_logic_array, pa_in, pb_in, pc_in, pd_in, batt_low, c} = '0;
		rst(c);
		for (int p = 0; p < 4; p++) rd({OFS_OUT_LATCH, p[1:0]}, REG_RST);
		for (int p = 0; p < 4; p++) rd({OFS_DIR, p[1:0]}, REG_RST);
		chk(pa_oe | pb_oe | pc_oe, 8'h00);
		$display("test reset values done");
		pb_in = 8'hC3;
		wr({OFS_OUT_LATCH, PORT_B}, 8'h5A);
		rd({OFS_OUT_LATCH, PORT_B}, 8'h5A);
		rd({OFS_PIN_IN, PORT_B}, 8'hC3);
		wr({OFS_DIR, PORT_B}, 8'h0F);
		chk(pb_oe, 8'h0F);
		chk(pb_out & pb_oe, 8'h0A);
		wr({OFS_OUT_LATCH, PORT_D}, 8'hFF);
		rd({OFS_OUT_LATCH, PORT_D}, MASK_D);
		wr({OFS_CTRL, PORT_C}, 8'hFF);
		rd({OFS_CTRL, PORT_C}, 8'h00);
		wr({OFS_CTRL, PORT_D}, 8'hFF);
		rd({OFS_CTRL, PORT_D}, 8'h00);
		rd(8'hFC, 8'h00);
		$display("test registers done");
		wr({OFS_DIR, PORT_A}, 8'hFF);
		wr({OFS_OUT_LATCH, PORT_A}, 8'hA5);
		wr({OFS_DRIVE, PORT_A}, 8'hFF);
		chk(pa_fast_slew, SLEW_MASK_AB);
		chk({pa_out[7:4], pa_oe[7:4]}, 8'h05);
		wr({OFS_DIR, PORT_C}, 8'hFF);
		wr({OFS_OUT_LATCH, PORT_C}, 8'h0F);
		wr({OFS_DRIVE, PORT_C}, 8'hFF);
		chk(pc_oe | pc_out, 8'hF0);
		wr({OFS_DRIVE, PORT_D}, 8'h07);
		chk({5'h00, pd_fast_slew}, 8'h07);
		i_pio_mcu.hold = 8;
		rd({OFS_OUT_LATCH, PORT_A}, 8'hA5);
		i_pio_mcu.hold = 4;
		$display("test drive done");
		c.latch_addr_in = 1'b1;
		rst(c);
		wr({OFS_CTRL, PORT_A}, 8'hFF);
		wr({OFS_DIR, PORT_A}, 8'hFF);
		{pa_in, pb_in} = {8'h44, 8'h11};
		i_pio_mcu.strobe(8'h96);
		{pa_in, pb_in} = {8'h55, 8'h22};
		repeat (5) @(posedge clk_sys) #1;
		chk(pa_out, 8'h96);
		chk(addr_in_b, 8'h11);
		chk(addr_in_a, 8'h44);
		$display("test address done");
		c = '0;
		{c.gsel_a, c.gsel_d, c.c_jtag} = {8'h0F, 3'h7, 8'h03};
		c.gsel_b = 8'hFF;
		{general_logic_array.b_o, general_logic_array.b_oe} = {8'h3C, 8'h0F};
		{c.stby_on_c2, c.dbe_on_c7, c.batt_on_c4} = 3'b111;
		{general_logic_array.a_o, general_logic_array.a_oe, general_logic_array.d_o, general_logic_array.d_oe} = {8'h09, 8'h0F, 3'h5, 3'h7};
		{batt_low, pc_in} = {1'b1, 8'hFF};
		rst(c);
		wr({OFS_DIR, PORT_C}, 8'hFF);
		wr({OFS_OUT_LATCH, PORT_C}, 8'hFF);
		chk(pa_out & 8'h0F, 8'h09);
		chk(pb_out, 8'h3C);
		chk(pb_oe, 8'h0F);
		chk({7'h00, data_byte_enable}, 8'h01);
		chk({5'h00, pd_out}, 8'h05);
		chk(pc_oe & 8'h87, 8'h00);
		chk(pc_out & pc_oe & 8'h10, 8'h10);
		rd({OFS_PIN_IN, PORT_C}, 8'hFC);
		batt_low = 1'b0;
		repeat (5) @(posedge clk_sys) #1;
		chk(pc_out & 8'h10, 8'h00);
		$display("test logic array done");
		c = '0;
		{c.a_data_port, c.ale_on_d0, c.clk_on_d1, c.csi_on_d2} = 4'hF;
		rst(c);
		pa_in = 8'h3C;
		wr({OFS_OUT_LATCH, PORT_B}, 8'h00);
		rd({OFS_OUT_LATCH, PORT_B}, 8'h3C);
		for (int v = 0; v < 8; v++) begin
			pd_in = v[2:0];
			repeat (5) @(posedge clk_sys) #1;
			chk({5'h00, mem_disable, common_clock_input, address_strobe}, {5'h00, pd_in});
		end
		pa_in = 8'h77;
		wr({OFS_OUT_LATCH, PORT_B}, 8'h00);
		rd({OFS_OUT_LATCH, PORT_B}, 8'h00);
		pd_in = 3'h0;
		repeat (5) @(posedge clk_sys) #1;
		rd({OFS_OUT_LATCH, PORT_B}, 8'h3C);
		$display("test dedicated pins done");
		test_done();
	end
endmodule : test_pio_port
`default_nettype wire
